/* File: synth_latch_powerdown_control.sv */
`timescale 1ns/1ps
`include "synth_latch_cfg.svh"
// Overview of operation
// R1 - Host loads reference, control, then feedback
// R2 - Host waits settle time before feedback write
// R3 - First control write powers device up unless its arm bit is set
// R4 - Power-down bits sit at 21, 20
// R5 - Arm without sync powers down immediately
// R6 - Sync arm waits two reference edges
// R7 - Chip enable low disables at once
// R8 - Power-down holds counters, pump, outputs off
// R9 - Shift register keeps working while down
// R10 - Host avoids feedback change while down
// R11 - Unchanged feedback relocks without band select
// R12 - Select 00 stores control latch
// R13 - Control latch holds prescaler select
// R14 - Two pump current codes stored
// R15 - Output level code stored
// R16 - Mute keeps outputs off until lock
// R17 - Gain bit picks pump current code
// R18 - MSB first shift, strobe rise transfers
// R19 - Select bits route word to latch
// R20 - Gain follows latest of two writes
// R21 - Band select on feedback update
// R22 - Test latch and spare bits harmless
module synth_latch_powerdown_control
  import synth_latch_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          arst_n,
  input  wire logic          serial_clk,
  input  wire logic          serial_data,
  input  wire logic          latch_strobe,
  input  wire logic          chip_enable,
  input  wire logic          lock_in,
  output logic               powered_down,
  output logic               bias_enable,
  output logic               ref_buffer_enable,
  output logic               pump_three_state,
  output logic               lock_detect_reset,
  output logic               counter_load_hold,
  output logic               rf_output_enable,
  output logic [2:0]         pump_current,
  output logic               band_select_start,
  output logic               ref_div_out,
  output control_latch_type  control_fields,
  output feedback_latch_type feedback_fields,
  output reference_latch_type reference_fields,
  output logic [`WORD_W-1:0] test_word
);

  // ----------------------------------------
  // Link domain: serial shift register
  // ----------------------------------------
  logic [`WORD_W-1:0] shift_ff;   // Word being shifted in
  logic [`WORD_W-1:0] nxt_shift;  // Next shift contents

  // R18 MSB-first shifting
  always_comb begin
    nxt_shift = {shift_ff[`WORD_W-2:0], serial_data};
  end

  // Runs on the link clock even while powered down
  // R9 input register stays live
  always_ff @(posedge serial_clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_ff <= `LATCH_RESET;
    end else begin
      shift_ff <= nxt_shift;
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [`SYNC_STAGES-1:0] pins_sync;  // {strobe, enable, lock}
  logic                    strobe_s;   // Strobe level, ref domain
  logic                    ce_s;       // Chip enable, ref domain
  logic                    lock_s;     // Lock report, ref domain

  pin_synchroniser #(.WIDTH(`SYNC_STAGES)) u_pins (
    .clk      (ref_clk),
    .arst_n   (arst_n),
    .async_in ({latch_strobe, chip_enable, lock_in}),
    .sync_out (pins_sync)
  );

  assign strobe_s = pins_sync[2];
  assign ce_s     = pins_sync[1];
  assign lock_s   = pins_sync[0];

  // ----------------------------------------
  // Strobe edge and word decode
  // ----------------------------------------
  logic          strobe_q_ff;  // Delayed strobe for edge
  logic          nxt_strobe_q; // Next delayed strobe
  logic          load_any;     // Strobe rise seen
  logic          load_ctrl;    // Word goes to control latch
  logic          load_ref;     // Word goes to reference latch
  logic          load_fb;      // Word goes to feedback latch
  logic          load_test;    // Word goes to test latch
  latch_sel_type word_sel;     // Routing bits of the word

  // Shift register is quiet here: host stops clocking before strobe
  // R19 select-bit routing
  always_comb begin
    nxt_strobe_q = strobe_s;
    load_any     = strobe_s && !strobe_q_ff;
    word_sel     = latch_sel_type'(shift_ff[`SEL_MSB:`SEL_LSB]);
    load_ctrl    = load_any && (word_sel == SEL_CONTROL);
    load_ref     = load_any && (word_sel == SEL_REFERENCE);
    load_fb      = load_any && (word_sel == SEL_FEEDBACK);
    load_test    = load_any && (word_sel == SEL_TEST);
  end

  // ----------------------------------------
  // Latches and power sequencing
  // ----------------------------------------
  control_latch_type   ctrl_ff,  nxt_ctrl;   // Control latch
  feedback_latch_type  fb_ff,    nxt_fb;     // Feedback divider latch
  reference_latch_type ref_ff,   nxt_ref;    // Reference divider latch
  logic [`WORD_W-1:0]  test_ff,  nxt_test;   // Test latch, no effect
  power_state_type     state_ff, nxt_state;  // Sequencing state
  logic [1:0]          edges_ff, nxt_edges;  // Reference edges seen
  logic                gain_ff,  nxt_gain;   // Shared pump gain
  logic                pend_ff,  nxt_pend;   // Feedback changed while down
  logic                pd_ff,    nxt_pd;     // Powered down
  logic                bias_ff,  nxt_bias;   // Bias and buffer on
  logic                band_ff,  nxt_band;   // Band select start pulse
  logic                rfen_ff,  nxt_rfen;   // Output stage on
  logic                tri_ff,   nxt_tri;    // Pump three-state
  logic                hold_ff,  nxt_hold;   // Counters held at load
  logic [2:0]          cur_ff,   nxt_cur;    // Active pump current
  logic [`REF_CNT_W-1:0] rcnt_ff, nxt_rcnt;  // Reference divider count
  logic                tick_ff,  nxt_tick;   // Reference output edge
  logic [`REF_CNT_W-1:0] rload;              // Divider reload value

  // Next state of latches and power control
  always_comb begin
    nxt_ctrl  = ctrl_ff;
    nxt_fb    = fb_ff;
    nxt_ref   = ref_ff;
    nxt_test  = test_ff;
    nxt_state = state_ff;
    nxt_edges = edges_ff;
    nxt_gain  = gain_ff;
    // R12 control store, R13 R14 R15 fields
    if (load_ctrl) begin
      nxt_ctrl = control_latch_type'(shift_ff);
    end
    if (load_ref) begin
      nxt_ref = reference_latch_type'(shift_ff);
    end
    // R22 spare and test bits kept, unused
    if (load_fb) begin
      nxt_fb = feedback_latch_type'(shift_ff);
    end
    if (load_test) begin
      nxt_test = shift_ff;
    end
    // R20 latest write wins
    if (load_fb) begin
      nxt_gain = shift_ff[`POS_GAIN_FB];
    end else if (load_ctrl) begin
      nxt_gain = shift_ff[`POS_GAIN_CTRL];
    end
    // R4 arm and sync bits
    case (state_ff)
      // R3 first control write powers up, or down if arm set
      ST_IDLE: begin
        if (load_ctrl) begin
          nxt_state = shift_ff[`POS_ARM] ? ST_DOWN : ST_RUN;
        end
      end
      ST_RUN: begin
        if (load_ctrl && shift_ff[`POS_ARM]) begin
          // R5 R6 immediate or gated
          nxt_state = shift_ff[`POS_SYNC_SELECT] ? ST_WAIT : ST_DOWN;
          nxt_edges = 2'h0;
        end
      end
      // R6 second reference edge
      ST_WAIT: begin
        if (load_ctrl && !shift_ff[`POS_ARM]) begin
          nxt_state = ST_RUN;
        end else if (tick_ff && (edges_ff == `SYNC_EDGES - 2'h1)) begin
          nxt_state = ST_DOWN;
        end else if (tick_ff) begin
          nxt_edges = edges_ff + 2'h1;
        end
      end
      ST_DOWN: begin
        if (load_ctrl && !shift_ff[`POS_ARM]) begin
          nxt_state = ST_RUN;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    // R7 chip enable overrides bits
    nxt_pd   = !ce_s || (nxt_state == ST_IDLE) || (nxt_state == ST_DOWN);
    // Own flop so the enable outputs need no inverter
    nxt_bias = !nxt_pd;
    // R21 R11 band select only on change
    nxt_band = !nxt_pd && (load_fb || pend_ff);
    nxt_pend = (pend_ff || load_fb) && nxt_pd;
    // R16 mute until lock
    nxt_rfen = !nxt_pd && (!nxt_ctrl.mute_until_locked || lock_s);
    // R8 power-down side effects
    nxt_tri  = nxt_pd || nxt_ctrl.pump_tristate;
    nxt_hold = nxt_pd || nxt_ctrl.counter_reset;
    // R17 gain picks code
    nxt_cur  = nxt_gain ? nxt_ctrl.pump_current_code_two : nxt_ctrl.pump_current_code_one;
  end

  // Reference divider; a zero ratio is treated as one
  always_comb begin
    rload    = (ref_ff.ref_count == '0) ? `REF_CNT_ONE : ref_ff.ref_count;
    nxt_tick = 1'b0;
    nxt_rcnt = rcnt_ff;
    // R8 counter forced to load state
    if (hold_ff) begin
      nxt_rcnt = rload;
    end else if (rcnt_ff <= `REF_CNT_ONE) begin
      nxt_rcnt = rload;
      nxt_tick = 1'b1;
    end else begin
      nxt_rcnt = rcnt_ff - `REF_CNT_ONE;
    end
  end

  // Registers of the ref domain
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      strobe_q_ff <= 1'b0;
      ctrl_ff     <= control_latch_type'(`LATCH_RESET);
      fb_ff       <= feedback_latch_type'(`LATCH_RESET);
      ref_ff      <= reference_latch_type'(`LATCH_RESET);
      test_ff     <= `LATCH_RESET;
      state_ff    <= ST_IDLE;
      edges_ff    <= 2'h0;
      gain_ff     <= 1'b0;
      pend_ff     <= 1'b0;
      pd_ff       <= 1'b1;
      bias_ff     <= 1'b0;
      band_ff     <= 1'b0;
      rfen_ff     <= 1'b0;
      tri_ff      <= 1'b1;
      hold_ff     <= 1'b1;
      cur_ff      <= 3'h0;
      rcnt_ff     <= `REF_CNT_ONE;
      tick_ff     <= 1'b0;
    end else begin
      strobe_q_ff <= nxt_strobe_q;
      ctrl_ff     <= nxt_ctrl;
      fb_ff       <= nxt_fb;
      ref_ff      <= nxt_ref;
      test_ff     <= nxt_test;
      state_ff    <= nxt_state;
      edges_ff    <= nxt_edges;
      gain_ff     <= nxt_gain;
      pend_ff     <= nxt_pend;
      pd_ff       <= nxt_pd;
      bias_ff     <= nxt_bias;
      band_ff     <= nxt_band;
      rfen_ff     <= nxt_rfen;
      tri_ff      <= nxt_tri;
      hold_ff     <= nxt_hold;
      cur_ff      <= nxt_cur;
      rcnt_ff     <= nxt_rcnt;
      tick_ff     <= nxt_tick;
    end
  end

  // ----------------------------------------
  // Outputs, all straight from flops
  // ----------------------------------------
  assign powered_down      = pd_ff;
  assign bias_enable       = bias_ff;
  assign ref_buffer_enable = bias_ff;
  assign lock_detect_reset = pd_ff;
  assign pump_three_state  = tri_ff;
  assign counter_load_hold = hold_ff;
  assign rf_output_enable  = rfen_ff;
  assign pump_current      = cur_ff;
  assign band_select_start = band_ff;
  assign ref_div_out       = tick_ff;
  assign control_fields    = ctrl_ff;
  assign feedback_fields   = fb_ff;
  assign reference_fields  = ref_ff;
  assign test_word         = test_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  property p_async_down;
    load_ctrl && (state_ff == ST_RUN) && shift_ff[`POS_ARM] && !shift_ff[`POS_SYNC_SELECT] |=> pd_ff;
  endproperty
  a_async_down: assert property (p_async_down) else $error("async power-down late"); // R5

  property p_sync_wait;
    load_ctrl && (state_ff == ST_RUN) && ce_s && shift_ff[`POS_ARM] && shift_ff[`POS_SYNC_SELECT]
      |=> !pd_ff && (state_ff == ST_WAIT);
  endproperty
  a_sync_wait: assert property (p_sync_wait) else $error("sync power-down not gated"); // R6

  property p_sync_second_edge;
    (state_ff == ST_WAIT) && tick_ff && (edges_ff == 2'h1) && !load_ctrl |=> (state_ff == ST_DOWN) && pd_ff;
  endproperty
  a_sync_second_edge: assert property (p_sync_second_edge) else $error("sync power-down edge wrong"); // R6

  property p_ce_low;
    !ce_s |=> pd_ff && !rfen_ff;
  endproperty
  a_ce_low: assert property (p_ce_low) else $error("chip enable low ignored"); // R7

  property p_down_effects;
    pd_ff |-> tri_ff && hold_ff && !rfen_ff && !band_ff;
  endproperty
  a_down_effects: assert property (p_down_effects) else $error("power-down side effect missing"); // R8

  property p_ctrl_store;
    load_ctrl |=> (ctrl_ff == $past(shift_ff));
  endproperty
  a_ctrl_store: assert property (p_ctrl_store) else $error("control latch not stored"); // R12

  property p_ref_store;
    load_ref |=> (ref_ff == $past(shift_ff)) && $stable(ctrl_ff);
  endproperty
  a_ref_store: assert property (p_ref_store) else $error("reference latch routing wrong"); // R19

  property p_gain_latest;
    load_fb |=> (gain_ff == $past(shift_ff[`POS_GAIN_FB])) ##1 (cur_ff == (gain_ff ?
      ctrl_ff.pump_current_code_two : ctrl_ff.pump_current_code_one));
  endproperty
  a_gain_latest: assert property (p_gain_latest) else $error("pump gain not latest"); // R20

  property p_mute;
    !pd_ff && ctrl_ff.mute_until_locked && !lock_s ##1 !lock_s && ctrl_ff.mute_until_locked |-> !rfen_ff;
  endproperty
  a_mute: assert property (p_mute) else $error("outputs on before lock"); // R16

  property p_band_on_fb;
    load_fb && !pd_ff && ce_s && (state_ff == ST_RUN) |=> band_ff ##1 !band_ff;
  endproperty
  a_band_on_fb: assert property (p_band_on_fb) else $error("band select not started"); // R21

  property p_no_band_relock;
    $rose(!pd_ff) && !$past(pend_ff) && !$past(load_fb) |-> !band_ff;
  endproperty
  a_no_band_relock: assert property (p_no_band_relock) else $error("needless band select"); // R11

  property p_test_quiet;
    load_test |=> $stable(ctrl_ff) && $stable(fb_ff) && $stable(ref_ff) && $stable(gain_ff);
  endproperty
  a_test_quiet: assert property (p_test_quiet) else $error("test latch disturbed operation"); // R22

  c_sync_down: cover property ((state_ff == ST_WAIT) ##[1:200] (state_ff == ST_DOWN));
  c_relock:    cover property ((state_ff == ST_DOWN) ##1 (state_ff == ST_RUN));
  c_band:      cover property (band_ff && rfen_ff == 1'b0);

endmodule

/* File: synth_latch_cfg.svh */
`ifndef SYNTH_LATCH_CFG_SVH
`define SYNTH_LATCH_CFG_SVH

// ----------------------------------------
// Serial word layout
// ----------------------------------------
`define WORD_W          24
`define SEL_LSB         0
`define SEL_MSB         1
`define POS_SYNC_SELECT 21
`define POS_ARM         20
`define POS_MUTE        11
`define POS_GAIN_CTRL   10
`define POS_GAIN_FB     21

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define LATCH_RESET     24'h000000
`define REF_CNT_W       14
`define REF_CNT_ONE     14'h0001
`define SYNC_EDGES      2'h2
`define SYNC_STAGES     3

`endif

/* File: synth_latch_pkg.sv */
package synth_latch_pkg;

  // ----------------------------------------
  // Latch routing codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    SEL_CONTROL   = 2'h0,
    SEL_REFERENCE = 2'h1,
    SEL_FEEDBACK  = 2'h2,
    SEL_TEST      = 2'h3
  } latch_sel_type;

  // ----------------------------------------
  // Power sequencing states, one-hot
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_RUN  = 4'h2,
    ST_WAIT = 4'h4,
    ST_DOWN = 4'h8
  } power_state_type;

  // ----------------------------------------
  // Control latch word
  // ----------------------------------------
  typedef struct packed {
    logic [1:0]    prescaler_select;
    logic          powerdown_sync_select;
    logic          powerdown_arm_bit;
    logic [2:0]    pump_current_code_two;
    logic [2:0]    pump_current_code_one;
    logic [1:0]    output_level_code;
    logic          mute_until_locked;
    logic          pump_gain_select;
    logic          pump_tristate;
    logic          detector_polarity;
    logic [2:0]    mux_select;
    logic          counter_reset;
    logic [1:0]    core_level;
    latch_sel_type sel;
  } control_latch_type;

  // ----------------------------------------
  // Feedback divider latch word
  // ----------------------------------------
  typedef struct packed {
    logic          halved_feedback_select;
    logic          output_halver_enable;
    logic          pump_gain_select;
    logic [12:0]   b_count;
    logic          spare_bit;
    logic [4:0]    a_count;
    latch_sel_type sel;
  } feedback_latch_type;

  // ----------------------------------------
  // Reference divider latch word
  // ----------------------------------------
  typedef struct packed {
    logic [1:0]    spare_bits;
    logic [1:0]    band_clock_divider;
    logic          factory_test_bit;
    logic          lock_count_select;
    logic [1:0]    pulse_width_code;
    logic [13:0]   ref_count;
    latch_sel_type sel;
  } reference_latch_type;

endpackage

/* File: pin_synchroniser.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Two-flop synchroniser, one per bit
// ----------------------------------------
module pin_synchroniser #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;     // First stage, read only by second
  logic [WIDTH-1:0] stable_ff;   // Second stage, safe to use
  logic [WIDTH-1:0] nxt_meta;    // Next first stage
  logic [WIDTH-1:0] nxt_stable;  // Next second stage

  // Next values
  always_comb begin
    nxt_meta   = async_in;
    nxt_stable = meta_ff;
  end

  // Registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff   <= '0;
      stable_ff <= '0;
    end else begin
      meta_ff   <= nxt_meta;
      stable_ff <= nxt_stable;
    end
  end

  assign sync_out = stable_ff;

endmodule

/* File: serial_host.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Host side of the three-wire link
// ----------------------------------------
module serial_host #(
  parameter int SETTLE_NS = 2000 // Shortened settle gap keeps the run brief
) (
  output logic serial_clk,
  output logic serial_data,
  output logic latch_strobe
);
  // ----------------------------------------
  // Idle levels
  // ----------------------------------------
  // One tick inside reset, then the clock stands still between frames
  initial begin
    serial_clk   = 1'b0;
    serial_data  = 1'b0;
    latch_strobe = 1'b0;
    #2 serial_clk = 1'b1;
    #3 serial_clk = 1'b0;
  end

  // ----------------------------------------
  // One 24-bit frame and its strobe
  // ----------------------------------------
  task automatic send_word(input logic [23:0] word);
    int i;
    // Odd offset keeps the link out of phase with the system clock
    #1.3;
    for (i = 23; i >= 0; i--) begin
      serial_data = word[i];
      #40 serial_clk = 1'b1;
      #40 serial_clk = 1'b0;
    end
    // Released data shows the inverse so a stale sample cannot pass
    #10 serial_data = ~word[0];
    #20 latch_strobe = 1'b1;
    #40 latch_strobe = 1'b0;
    #40;
  endtask

  // ----------------------------------------
  // Full start-up sequence
  // ----------------------------------------
  // fixed load order
  task automatic power_up(input logic [23:0] ref_w, input logic [23:0] ctrl_w, input logic [23:0] fb_w);
    send_word(ref_w);
    send_word(ctrl_w);
    #SETTLE_NS;
    send_word(fb_w);
  endtask
endmodule

/* File: tb.sv */
`timescale 1ns/1ps
`include "synth_latch_cfg.svh"
`define CHK(n, e, g) check(n, 24'(e), 24'(g))
module tb
  import synth_latch_pkg::*;
;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic                ref_clk, arst_n, chip_enable, lock_in;
  wire logic           serial_clk, serial_data, latch_strobe;
  logic                powered_down, bias_enable, ref_buffer_enable, pump_three_state;
  logic                lock_detect_reset, counter_load_hold, rf_output_enable;
  logic                band_select_start, ref_div_out;
  logic [2:0]          pump_current;
  control_latch_type   control_fields;
  feedback_latch_type  feedback_fields;
  reference_latch_type reference_fields;
  logic [`WORD_W-1:0]  test_word;
  int                  fail_count, check_count, band_count, div_count, n;
  logic [15:0]         lfsr;   // Random source, fixed seed
  logic [23:0]         w, ref_w, ctrl_w, fb_w;

  serial_host u_host (.serial_clk, .serial_data, .latch_strobe);

  synth_latch_powerdown_control u_dut (
    .ref_clk, .arst_n, .serial_clk, .serial_data, .latch_strobe, .chip_enable, .lock_in,
    .powered_down, .bias_enable, .ref_buffer_enable, .pump_three_state, .lock_detect_reset,
    .counter_load_hold, .rf_output_enable, .pump_current, .band_select_start, .ref_div_out,
    .control_fields, .feedback_fields, .reference_fields, .test_word
  );

  // ----------------------------------------
  // Clock and pulse monitors
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // One-cycle pulses are counted, never sampled late
  always @(posedge ref_clk) begin
    if (band_select_start === 1'b1) band_count++;
    if (ref_div_out === 1'b1 && powered_down === 1'b0) div_count++;
  end

  // Divider pulses are reckoned from each strobe rise
  always @(posedge latch_strobe) div_count = 0;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [23:0] rnd24();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    rnd24[15:0] = lfsr;
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    rnd24[23:16] = lfsr[7:0];
  endfunction

  // Random control word; tristate and counter reset kept clear
  function automatic logic [23:0] make_ctrl(input logic arm, input logic sync, input logic mute, input logic gain);
    logic [23:0] v;
    v = rnd24();
    v[`POS_SYNC_SELECT] = sync;
    v[`POS_ARM] = arm;
    v[`POS_MUTE] = mute;
    v[`POS_GAIN_CTRL] = gain;
    v[9] = 1'b0;
    v[4] = 1'b0;
    v[1:0] = 2'h0;
    return v;
  endfunction

  function automatic logic [2:0] exp_pump(input logic [23:0] c, input logic g);
    return g ? c[19:17] : c[16:14];
  endfunction

  task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic send(input logic [23:0] v);
    u_host.send_word(v);
    repeat (4) @(negedge ref_clk);
  endtask

  // Side outputs that follow the power state
  task automatic side_chk(input logic dn);
    `CHK("powered_down", dn, powered_down);
    `CHK("bias_enable", !dn, bias_enable);
    `CHK("ref_buffer_enable", !dn, ref_buffer_enable);
    `CHK("lock_detect_reset", dn, lock_detect_reset);
    `CHK("pump_three_state", dn, pump_three_state);
    `CHK("counter_load_hold", dn, counter_load_hold);
    if (dn) `CHK("rf_output_enable", 1'b0, rf_output_enable);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    #300000;
    fail_count++;
    $display("unexpected watchdog expected done seen hang");
    stop_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    fail_count = 0;
    check_count = 0;
    band_count = 0;
    lfsr = 16'h94A8;
    arst_n = 1'b0;
    chip_enable = 1'b1;
    lock_in = 1'b0;
    repeat (2) @(negedge ref_clk);
    arst_n = 1'b1;
    `CHK("powered_down", 1'b1, powered_down);
    `CHK("control_fields", 24'h000000, control_fields);
    // Start-up in the documented order
    ref_w = rnd24();
    ref_w[15:2] = 14'h0014;
    ref_w[1:0] = 2'h1;
    send(ref_w);
    `CHK("powered_down", 1'b1, powered_down);
    ctrl_w = make_ctrl(1'b0, 1'b0, 1'b0, 1'b0);
    send(ctrl_w);
    `CHK("powered_down", 1'b0, powered_down);
    #2000;
    fb_w = rnd24();
    fb_w[`POS_GAIN_FB] = 1'b0;
    fb_w[1:0] = 2'h2;
    send(fb_w);
    `CHK("reference_fields", ref_w, reference_fields);
    `CHK("control_fields", ctrl_w, control_fields);
    `CHK("feedback_fields", fb_w, feedback_fields);
    side_chk(1'b0);
    `CHK("rf_output_enable", 1'b1, rf_output_enable);
    `CHK("pump_current", exp_pump(ctrl_w, 1'b0), pump_current);
    `CHK("band_count", 1, band_count);
    // Gain written last through either latch wins
    fb_w[`POS_GAIN_FB] = 1'b1;
    send(fb_w);
    `CHK("pump_current", exp_pump(ctrl_w, 1'b1), pump_current);
    `CHK("band_count", 2, band_count);
    ctrl_w = make_ctrl(1'b0, 1'b0, 1'b0, 1'b0);
    send(ctrl_w);
    `CHK("pump_current", exp_pump(ctrl_w, 1'b0), pump_current);
    // Random control fields
    for (n = 0; n < 4; n++) begin
      ctrl_w = make_ctrl(1'b0, 1'b0, 1'b0, lfsr[3]);
      send(ctrl_w);
      `CHK("control_fields", ctrl_w, control_fields);
      `CHK("pump_current", exp_pump(ctrl_w, ctrl_w[`POS_GAIN_CTRL]), pump_current);
    end
    // Test latch is stored but inert
    w = rnd24();
    w[1:0] = 2'h3;
    send(w);
    `CHK("test_word", w, test_word);
    `CHK("control_fields", ctrl_w, control_fields);
    `CHK("powered_down", 1'b0, powered_down);
    // Immediate software power-down
    send(make_ctrl(1'b1, 1'b0, 1'b0, 1'b0));
    side_chk(1'b1);
    ref_w[23:16] = ~ref_w[23:16];
    send(ref_w);
    `CHK("reference_fields", ref_w, reference_fields);
    n = band_count;
    send(make_ctrl(1'b0, 1'b0, 1'b0, 1'b0));
    side_chk(1'b0);
    `CHK("band_count", n, band_count);
    // Power-down gated by two divider edges
    send(make_ctrl(1'b1, 1'b1, 1'b0, 1'b0));
    `CHK("powered_down", 1'b0, powered_down);
    for (n = 0; n < 100 && powered_down !== 1'b1; n++) @(negedge ref_clk);
    `CHK("sync_edges", (div_count == 2 || div_count == 3), 1'b1);
    side_chk(1'b1);
    // Feedback change while down needs the full sequence
    n = band_count;
    fb_w[15:8] = ~fb_w[15:8];
    send(fb_w);
    `CHK("band_count", n, band_count);
    u_host.power_up(ref_w, make_ctrl(1'b0, 1'b0, 1'b0, 1'b0), fb_w);
    repeat (4) @(negedge ref_clk);
    `CHK("band_count", n + 2, band_count);
    // Pin disable overrides the control bits
    n = band_count;
    chip_enable = 1'b0;
    repeat (5) @(negedge ref_clk);
    side_chk(1'b1);
    chip_enable = 1'b1;
    repeat (3) @(negedge ref_clk);
    send(make_ctrl(1'b0, 1'b0, 1'b0, 1'b0));
    side_chk(1'b0);
    `CHK("band_count", n, band_count);
    // Outputs muted until lock
    send(make_ctrl(1'b0, 1'b0, 1'b1, 1'b0));
    `CHK("rf_output_enable", 1'b0, rf_output_enable);
    lock_in = 1'b1;
    repeat (6) @(negedge ref_clk);
    `CHK("rf_output_enable", 1'b1, rf_output_enable);
    lock_in = 1'b0;
    repeat (6) @(negedge ref_clk);
    `CHK("rf_output_enable", 1'b0, rf_output_enable);
    stop_test();
  end
endmodule
